// ==== hw/timer3_control.v ====
// What this block does
// - Control holds flip-flop init, clock select, start and mode; resets 0.
// - Normal modes pick fc taps, fs, fc or pin; 000 is fs/2^3 with tap set.
// - Slow modes allow only 000, 100, 110 (warm-up only) and the pin.
// - Start 0 stops and clears the up counter, start 1 starts counting.
// - Mode 000 timer, 001 divider, 010 PWM, 011 16-bit, 1xx reserved.
// - In 16-bit use mode stays 011 and the function comes from counter 4.
// - In 16-bit use clock is from counter 3, start and init from counter 4.
// - Each counter has an 8-bit period and an 8-bit pulse-width register.
// - Counter 3 pulse width changes while running only in PWM modes.
// - Counter 4 period stays while running, pulse width only in PWM modes.
// - A counter 4 mode with top bit set clocks it from counter 3 overflow.
`timescale 1ns/1ns
`include "timer3_consts.vh"

module timer3_control (
  input  wire                CLK,
  input  wire                NRST,
  input  wire [`ADDR_W-1:0]  ADDR,
  input  wire [7:0]          WDATA,
  input  wire                WR,
  input  wire                RD,
  output reg  [7:0]          RDATA,
  input  wire                SLOW_MODE,
  input  wire                WARMUP_EN,
  output reg                 T3_RUN,
  output reg                 T3_FF_INIT,
  output reg  [3:0]          T3_CLK_SRC,
  output reg  [2:0]          T3_FUNCTION,
  output reg                 T3_COUNTER_CLR,
  output reg                 T4_RUN,
  output reg  [3:0]          T4_CLK_SRC,
  output reg  [7:0]          T3_PERIOD,
  output reg  [7:0]          T3_PULSE_WIDTH,
  output reg  [7:0]          T4_PERIOD,
  output reg  [7:0]          T4_PULSE_WIDTH,
  output reg                 WRITE_VIOLATION,
  output reg                 CLOCK_INVALID
);

  // ****************************************
  // Registers
  // ****************************************
  reg  [7:0] timer3_control_ff;
  reg  [7:0] timer4_control_ff;
  reg  [7:0] t3_period_ff;
  reg  [7:0] t3_pulse_ff;
  reg  [7:0] t4_period_ff;
  reg  [7:0] t4_pulse_ff;
  reg        prescaler_tap_select_ff;
  reg        viol_ff;

  wire [2:0] t3_ck   = timer3_control_ff[`F_CK_HI:`F_CK_LO];
  wire [2:0] t3_mode = timer3_control_ff[`F_MODE_HI:`F_MODE_LO];
  wire [2:0] t4_ck   = timer4_control_ff[`F_CK_HI:`F_CK_LO];
  wire [2:0] t4_mode = timer4_control_ff[`F_MODE_HI:`F_MODE_LO];
  wire       cascade = (t3_mode == `MODE_CASCADE);
  wire       t3_run  = timer3_control_ff[`F_RUN];
  wire       t4_run  = timer4_control_ff[`F_RUN];

  // ****************************************
  // Functions
  // ****************************************

  // Clock select to source, per power mode
  function [3:0] clk_src;
    input [2:0] ck;
    input       slow;
    input       tap;
    input       warm;
    begin
      clk_src = `SRC_NONE;
      case (ck)
        `CK_DIV11: clk_src = (slow | tap) ? `SRC_FS_D3 : `SRC_FC_D11;
        `CK_DIV7:  clk_src = slow ? `SRC_NONE : `SRC_FC_D7;
        `CK_DIV5:  clk_src = slow ? `SRC_NONE : `SRC_FC_D5;
        `CK_DIV3:  clk_src = slow ? `SRC_NONE : `SRC_FC_D3;
        `CK_FS:    clk_src = `SRC_FS;
        `CK_DIV1:  clk_src = slow ? `SRC_NONE : `SRC_FC_D1;
        `CK_FC:    clk_src = (slow & ~warm) ? `SRC_NONE : `SRC_FC;
        `CK_PIN:   clk_src = `SRC_PIN;
        default:   clk_src = `SRC_NONE;
      endcase
    end
  endfunction

  // Write hits a given address
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] b;
    input               w;
    begin
      hit = w & (a == b);
    end
  endfunction

  // Control write that alters held fields while running
  function ctrl_misuse;
    input       w;
    input       run;
    input [7:0] nxt;
    input [7:0] cur;
    begin
      ctrl_misuse = w & run &
                    (((nxt ^ cur) & `CTRL_HOLD_MASK) != `RST_BYTE);
    end
  endfunction

  // Timer register write while running, unless the mode allows it
  function reg_misuse;
    input w;
    input run;
    input allowed;
    begin
      reg_misuse = w & run & ~allowed;
    end
  endfunction

  // Counter 4 PWM modes, whose pulse width may change while running
  function pwm_mode;
    input [2:0] mode;
    begin
      pwm_mode = (mode == `MODE_PWM) | (mode == `MODE4_PWM16);
    end
  endfunction

  // ****************************************
  // Register writes
  // ****************************************
  wire wr_c3 = hit(ADDR, `A_TIMER3_CONTROL, WR);
  wire wr_c4 = hit(ADDR, `A_TIMER4_CONTROL, WR);
  wire wr_p3 = hit(ADDR, `A_TIMER3_PERIOD, WR);
  wire wr_w3 = hit(ADDR, `A_TIMER3_PULSE, WR);
  wire wr_p4 = hit(ADDR, `A_TIMER4_PERIOD, WR);
  wire wr_w4 = hit(ADDR, `A_TIMER4_PULSE, WR);
  wire wr_st = hit(ADDR, `A_TIMER_STATUS, WR);
  wire wr_pc = hit(ADDR, `A_PRESCALE_CFG, WR);

  // Effective run state of each counter's period logic
  wire run3_eff = cascade ? t4_run : t3_run;
  wire pwm3     = (t3_mode == `MODE_PWM) |
                  (cascade & (t4_mode == `MODE4_PWM16));
  wire pwm4     = pwm_mode(t4_mode);

  // ****************************************
  // Misuse detection
  // ****************************************

  // Software-side restrictions, flagged rather than refused
  reg nxt_viol;
  always @* begin
    nxt_viol = 1'h0;
    if (ctrl_misuse(wr_c3, t3_run, WDATA, timer3_control_ff))
      nxt_viol = 1'h1;
    if (ctrl_misuse(wr_c4, t4_run, WDATA, timer4_control_ff))
      nxt_viol = 1'h1;
    if (reg_misuse(wr_p3, run3_eff, 1'h0))
      nxt_viol = 1'h1;
    if (reg_misuse(wr_w3, run3_eff, pwm3))
      nxt_viol = 1'h1;
    if (reg_misuse(wr_p4, t4_run, 1'h0))
      nxt_viol = 1'h1;
    if (reg_misuse(wr_w4, t4_run, pwm4))
      nxt_viol = 1'h1;
  end

  // Control registers, stored even when misused
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      timer3_control_ff <= `RST_BYTE;
      timer4_control_ff <= `RST_BYTE;
    end else begin
      if (wr_c3)
        timer3_control_ff <= WDATA;
      if (wr_c4)
        timer4_control_ff <= WDATA;
    end
  end

  // Period and pulse-width registers of both counters
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      t3_period_ff <= `RST_BYTE;
      t3_pulse_ff  <= `RST_BYTE;
      t4_period_ff <= `RST_BYTE;
      t4_pulse_ff  <= `RST_BYTE;
    end else begin
      if (wr_p3)
        t3_period_ff <= WDATA;
      if (wr_w3)
        t3_pulse_ff <= WDATA;
      if (wr_p4)
        t4_period_ff <= WDATA;
      if (wr_w4)
        t4_pulse_ff <= WDATA;
    end
  end

  // Prescaler tap select bit
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      prescaler_tap_select_ff <= 1'h0;
    else if (wr_pc)
      prescaler_tap_select_ff <= WDATA[`F_TAP];
  end

  // Sticky misuse flag, set wins over clear
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      viol_ff <= 1'h0;
    else if (nxt_viol)
      viol_ff <= 1'h1;
    else if (wr_st && WDATA[`F_VIOL])
      viol_ff <= 1'h0;
  end

  // ****************************************
  // Read port
  // ****************************************
  reg [7:0] nxt_rdata;
  always @* begin
    nxt_rdata = `RST_BYTE;
    case (ADDR)
      `A_TIMER3_CONTROL: nxt_rdata = timer3_control_ff;
      `A_TIMER4_CONTROL: nxt_rdata = timer4_control_ff;
      `A_TIMER3_PERIOD:  nxt_rdata = t3_period_ff;
      `A_TIMER3_PULSE:   nxt_rdata = t3_pulse_ff;
      `A_TIMER4_PERIOD:  nxt_rdata = t4_period_ff;
      `A_TIMER4_PULSE:   nxt_rdata = t4_pulse_ff;
      `A_TIMER_STATUS:   nxt_rdata = {`STAT_PAD, CLOCK_INVALID, run3_eff,
                                      viol_ff};
      `A_PRESCALE_CFG:   nxt_rdata = {`CFG_PAD, prescaler_tap_select_ff};
      default:           nxt_rdata = `RST_BYTE;
    endcase
  end

  // ****************************************
  // Decoded control
  // ****************************************
  reg [3:0] nxt_t3_src;
  reg [3:0] nxt_t4_src;
  reg [2:0] nxt_fn;
  always @* begin
    nxt_t3_src = clk_src(t3_ck, SLOW_MODE, prescaler_tap_select_ff,
                         WARMUP_EN);
    nxt_t4_src = clk_src(t4_ck, SLOW_MODE, prescaler_tap_select_ff,
                         WARMUP_EN);
    if (t4_mode[`F_MODE_TOP])
      nxt_t4_src = `SRC_T3_OVF;
    case (t3_mode)
      `MODE_TIMER:   nxt_fn = `FN_TIMER8;
      `MODE_PDO:     nxt_fn = `FN_PDO8;
      `MODE_PWM:     nxt_fn = `FN_PWM8;
      `MODE_CASCADE: nxt_fn = `FN_CASCADE16;
      default:       nxt_fn = `FN_RESERVED;
    endcase
  end

  // ****************************************
  // Output registers
  // ****************************************

  // Read data, zero outside the read slot
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      RDATA <= `RST_BYTE;
    else if (RD)
      RDATA <= nxt_rdata;
    else
      RDATA <= `RST_BYTE;
  end

  // Run of both counters, clear and flip-flop init of counter 3
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      T3_RUN         <= 1'h0;
      T3_FF_INIT     <= 1'h0;
      T3_COUNTER_CLR <= 1'h1;
      T4_RUN         <= 1'h0;
    end else begin
      T3_RUN         <= run3_eff;
      T3_FF_INIT     <= cascade ? timer4_control_ff[`F_FFI]
                                : timer3_control_ff[`F_FFI];
      T3_COUNTER_CLR <= ~run3_eff;
      T4_RUN         <= t4_run;
    end
  end

  // Source clocks and the power-mode check
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      T3_CLK_SRC    <= `SRC_NONE;
      T4_CLK_SRC    <= `SRC_NONE;
      CLOCK_INVALID <= 1'h0;
    end else begin
      T3_CLK_SRC    <= nxt_t3_src;
      T4_CLK_SRC    <= nxt_t4_src;
      CLOCK_INVALID <= (nxt_t3_src == `SRC_NONE);
    end
  end

  // Decoded operating function
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      T3_FUNCTION <= `FN_TIMER8;
    else
      T3_FUNCTION <= nxt_fn;
  end

  // Timer register copies for the counting logic
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      T3_PERIOD      <= `RST_BYTE;
      T3_PULSE_WIDTH <= `RST_BYTE;
      T4_PERIOD      <= `RST_BYTE;
      T4_PULSE_WIDTH <= `RST_BYTE;
    end else begin
      T3_PERIOD      <= t3_period_ff;
      T3_PULSE_WIDTH <= t3_pulse_ff;
      T4_PERIOD      <= t4_period_ff;
      T4_PULSE_WIDTH <= t4_pulse_ff;
    end
  end

  // Misuse flag to the pin, one cycle behind the status bit
  always @(posedge CLK or negedge NRST) begin
    if (!NRST)
      WRITE_VIOLATION <= 1'h0;
    else
      WRITE_VIOLATION <= viol_ff;
  end

endmodule

// ==== hw/timer3_consts.vh ====
`ifndef TIMER3_CONSTS_VH
`define TIMER3_CONSTS_VH

// ****************************************
// Register map
// ****************************************
`define ADDR_W            8
`define A_TIMER3_CONTROL  8'h16
`define A_TIMER4_CONTROL  8'h17
`define A_TIMER3_PERIOD   8'h18
`define A_TIMER3_PULSE    8'h19
`define A_TIMER4_PERIOD   8'h1A
`define A_TIMER4_PULSE    8'h1B
`define A_TIMER_STATUS    8'h1C
`define A_PRESCALE_CFG    8'h1D
`define RST_BYTE          8'h00

// ****************************************
// Status and configuration fields
// ****************************************
`define CTRL_HOLD_MASK    8'hF7
`define F_VIOL            0
`define F_TAP             0
`define STAT_PAD          5'h00
`define CFG_PAD           7'h00

// ****************************************
// Control register fields
// ****************************************
`define F_FFI             7
`define F_CK_HI           6
`define F_CK_LO           4
`define F_RUN             3
`define F_MODE_HI         2
`define F_MODE_LO         0
`define F_MODE_TOP        2

// ****************************************
// Clock select codes
// ****************************************
`define CK_DIV11          3'h0
`define CK_DIV7           3'h1
`define CK_DIV5           3'h2
`define CK_DIV3           3'h3
`define CK_FS             3'h4
`define CK_DIV1           3'h5
`define CK_FC             3'h6
`define CK_PIN            3'h7

// ****************************************
// Source encodings (output)
// ****************************************
`define SRC_NONE          4'h0
`define SRC_FC_D11        4'h1
`define SRC_FC_D7         4'h2
`define SRC_FC_D5         4'h3
`define SRC_FC_D3         4'h4
`define SRC_FS            4'h5
`define SRC_FC_D1         4'h6
`define SRC_FC            4'h7
`define SRC_PIN           4'h8
`define SRC_FS_D3         4'h9
`define SRC_T3_OVF        4'hA

// ****************************************
// Mode codes
// ****************************************
`define MODE_TIMER        3'h0
`define MODE_PDO          3'h1
`define MODE_PWM          3'h2
`define MODE_CASCADE      3'h3
`define MODE4_PWM16       3'h6

// ****************************************
// Decoded function (output)
// ****************************************
`define FN_TIMER8         3'h0
`define FN_PDO8           3'h1
`define FN_PWM8           3'h2
`define FN_CASCADE16      3'h3
`define FN_RESERVED       3'h4

`endif

// ==== verification/timer3_checker.sv ====
`timescale 1ns/1ns
`include "timer3_consts.vh"
// ****************************************
// Control checker
// ****************************************
module timer3_checker (
  input wire       CLK,
  input wire       NRST,
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire       WR,
  input wire       RD,
  input wire [7:0] RDATA,
  input wire       T3_RUN,
  input wire       T3_FF_INIT,
  input wire [2:0] T3_FUNCTION,
  input wire       T3_COUNTER_CLR,
  input wire [3:0] T4_CLK_SRC
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  // Own-mode control write (not cascade)
  wire c3 = WR && ADDR == `A_TIMER3_CONTROL && WDATA[2:0] != `MODE_CASCADE;
  wire w4 = WR && ADDR == `A_TIMER4_CONTROL;
  chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside read slot");
  chk_unmapped_zero: assert property (RD && ADDR > 8'h1D |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_start_run: assert property (c3 && WDATA[3] |-> ##2 T3_RUN)
    else $error("start write did not run");
  chk_stop_clear: assert property (
    c3 && !WDATA[3] |-> ##2 T3_COUNTER_CLR)
    else $error("stop write did not clear");
  chk_mode_decode: assert property (c3 |-> ##2 T3_FUNCTION ==
    ($past(WDATA[2], 2) ? `FN_RESERVED : $past(WDATA[2:0], 2)))
    else $error("mode decode wrong");
  chk_ff_follow: assert property (
    c3 |-> ##2 T3_FF_INIT == $past(WDATA[7], 2))
    else $error("flip-flop init wrong");
  chk_clr_inverse: assert property (T3_COUNTER_CLR != T3_RUN)
    else $error("clear and run disagree");
  chk_t4_ovf: assert property (
    w4 && WDATA[2] |-> ##2 T4_CLK_SRC == `SRC_T3_OVF)
    else $error("upper byte clock not overflow");
  // Main scenarios
  cover property (c3 && WDATA[3]);
  cover property (w4 && WDATA[2]);
  cover property (RD && ADDR == `A_TIMER3_CONTROL);
endmodule
bind timer3_control timer3_checker timer3_checker_inst (.CLK(CLK),
  .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .T3_RUN(T3_RUN), .T3_FF_INIT(T3_FF_INIT), .T3_FUNCTION(T3_FUNCTION),
  .T3_COUNTER_CLR(T3_COUNTER_CLR), .T4_CLK_SRC(T4_CLK_SRC));

// ==== verification/test_timer3_control.sv ====
`timescale 1ns/1ns
`include "timer3_consts.vh"
`define CHK(g, e) chk(g, e)
module test_timer3_control;
  reg        CLK = 0, NRST = 0, WR = 0, RD = 0, SLOW_MODE = 0, WARMUP_EN = 0;
  reg  [7:0] ADDR = 8'h00, WDATA = 8'h00, q, d;
  wire [7:0] RDATA, T3_PERIOD, T3_PULSE_WIDTH, T4_PERIOD, T4_PULSE_WIDTH;
  wire [3:0] T3_CLK_SRC, T4_CLK_SRC;
  wire [2:0] T3_FUNCTION;
  wire       T3_RUN, T3_FF_INIT, T3_COUNTER_CLR, T4_RUN, WRITE_VIOLATION;
  wire       CLOCK_INVALID;
  int        err_total = 0, n_compared = 0, cyc = 0, m, c, s, w;
  timer3_control timer3_control_inst (.CLK(CLK), .NRST(NRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLOW_MODE(SLOW_MODE),
    .WARMUP_EN(WARMUP_EN), .T3_RUN(T3_RUN), .T3_FF_INIT(T3_FF_INIT),
    .T3_CLK_SRC(T3_CLK_SRC), .T3_FUNCTION(T3_FUNCTION),
    .T3_COUNTER_CLR(T3_COUNTER_CLR), .T4_RUN(T4_RUN),
    .T4_CLK_SRC(T4_CLK_SRC), .T3_PERIOD(T3_PERIOD),
    .T3_PULSE_WIDTH(T3_PULSE_WIDTH), .T4_PERIOD(T4_PERIOD),
    .T4_PULSE_WIDTH(T4_PULSE_WIDTH), .WRITE_VIOLATION(WRITE_VIOLATION),
    .CLOCK_INVALID(CLOCK_INVALID));
  // ****************************************
  // Clock, timeout, helpers
  // ****************************************
  always #25 CLK = ~CLK;
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim;
    end
  end
  task end_sim;
    $display("errors %0d compares %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [7:0] g, input [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Write, then let decoded outputs settle
  task wr(input [7:0] a, input [7:0] v);
    @(posedge CLK); WR <= 1; ADDR <= a; WDATA <= v;
    @(posedge CLK); WR <= 0;
    @(posedge CLK); #1;
  endtask
  task rd(input [7:0] a);
    @(posedge CLK); RD <= 1; ADDR <= a;
    @(posedge CLK); RD <= 0;
    #1 q = RDATA;
  endtask
  // Read sticky flag, then clear it
  task viol(input e);
    rd(8'h1C); `CHK(q[0], e);
    `CHK(WRITE_VIOLATION, e);
    wr(8'h1C, 8'h01);
  endtask
  // Expected source for a select code
  function [3:0] src(input [2:0] k, input sl, input tp, input wm);
    case (k)
      3'h0: src = (sl || tp) ? 4'h9 : 4'h1;
      3'h4: src = 4'h5;
      3'h6: src = (!sl || wm) ? 4'h7 : 4'h0;
      3'h7: src = 4'h8;
      default: src = sl ? 4'h0 : k + 4'h1;
    endcase
  endfunction
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    `CHK(T3_COUNTER_CLR, 1'b1);
    for (m = 8'h16; m <= 8'h1D; m++) begin
      rd(m[7:0]); `CHK(q, 8'h00);
    end
  endtask
  task t_clock;
    for (s = 0; s < 2; s++)
      for (w = 0; w < 2; w++)
        for (c = 0; c < 8; c++) begin
      @(posedge CLK); SLOW_MODE <= s[0]; WARMUP_EN <= w[0];
      wr(8'h16, {1'b0, c[2:0], 4'h0});
      `CHK(T3_CLK_SRC, src(c[2:0], s[0], 1'b0, w[0]));
      `CHK(CLOCK_INVALID, src(c[2:0], s[0], 1'b0, w[0]) == 4'h0);
    end
    @(posedge CLK); SLOW_MODE <= 0;
    wr(8'h1D, 8'h01); wr(8'h16, 8'h00);
    `CHK(T3_CLK_SRC, 4'h9);
    wr(8'h1D, 8'h00);
  endtask
  task t_mode;
    for (m = 0; m < 8; m++) begin
      d = {m[0], 4'h0, m[2:0]};
      wr(8'h16, d); `CHK(T3_RUN, 1'b0);
      wr(8'h16, d | 8'h08); `CHK(T3_RUN, m != 3);
      `CHK(T3_FUNCTION, m[2] ? 3'h4 : m[2:0]);
      `CHK(T3_FF_INIT, m != 3 && m[0]);
      rd(8'h16); `CHK(q, d | 8'h08);
      wr(8'h16, d);
    end
    viol(1'b0);
  endtask
  task t_casc;
    wr(8'h16, 8'h03); wr(8'h17, 8'h8C);
    `CHK({T3_RUN, T3_FF_INIT, T4_RUN}, 8'h07);
    `CHK(T4_CLK_SRC, 4'hA);
    `CHK(T3_FUNCTION, 3'h3);
    `CHK(T3_CLK_SRC, 4'h1);
    wr(8'h17, 8'h84); `CHK({T3_RUN, T3_COUNTER_CLR}, 8'h01);
    wr(8'h16, 8'h00);
  endtask
  task t_regs;
    for (m = 0; m < 4; m++) begin
      wr(8'h18 + m[7:0], 8'hA0 + m[7:0]);
      rd(8'h18 + m[7:0]); `CHK(q, 8'hA0 + m[7:0]);
    end
    `CHK(T3_PERIOD, 8'hA0);
    `CHK(T3_PULSE_WIDTH, 8'hA1);
    `CHK(T4_PERIOD, 8'hA2);
    `CHK(T4_PULSE_WIDTH, 8'hA3);
    wr(8'h16, 8'h08); wr(8'h18, 8'h11); viol(1'b1);
    wr(8'h19, 8'h22); viol(1'b1);
    wr(8'h16, 8'h00); wr(8'h16, 8'h0A); wr(8'h19, 8'h33); viol(1'b0);
    wr(8'h16, 8'h0B); viol(1'b1);
    wr(8'h16, 8'h03); wr(8'h17, 8'h08); wr(8'h1A, 8'h44); viol(1'b1);
    wr(8'h17, 8'h00);
    wr(8'h30, 8'h5A); rd(8'h30); `CHK(q, 8'h00);
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1;
    t_reset;
    t_clock;
    t_mode;
    t_casc;
    t_regs;
    end_sim;
  end
endmodule
